// [rtl/snoop_crc_unit.sv]
// Functional notes
// RQ1 - Snoop reads on code-data and system buses
// RQ2 - Capture only mirrored-region read addresses
// RQ3 - Fold captured byte, update result register
// RQ4 - Result readable anytime, holds accumulated CRC
// RQ5 - Only byte reads contribute to CRC
// RQ6 - Debugger reads never change the result
// RQ7 - Support CRC8 0x07 and CRC32
// RQ8 - Support CRC16 0x8005 and 0x1021
// RQ9 - Writing clear resets result register
// RQ10 - Configuration selects one of four polynomials
// RQ11 - Result register accepts arbitrary software writes
// RQ12 - Software saves, clears, selects, reads, restores
// RQ13 - Cross-zone reads are blocked from CRC
// RQ14 - Execute-only sectors allowed from owning zone
// RQ15 - Execute-only dummy reads give CPU nothing
// RQ16 - Protected reads return zero without stall
// RQ17 - MSB first, no reflection, clear zeroes
`timescale 1ns/1ps
`default_nettype none
module snoop_crc_unit (
  input  wire logic  core_clk_i,
  input  wire logic  rst_n_i,
  snoop_bus_if.unit  bus
);
  // ==========================================================
  // Per-bus view: index 0 is the code-data bus, index 1 the system bus
  localparam int BUS_N = 2;
  localparam int CD    = 0;
  localparam int SB    = 1;

  logic [BUS_N-1:0] valid_v;
  logic [BUS_N-1:0] dbg_v;
  logic [BUS_N-1:0] zone_v;
  logic [BUS_N-1:0] owner_v;
  logic [BUS_N-1:0] prot_v;
  logic [BUS_N-1:0] xonly_v;
  logic [BUS_N-1:0] blocked_v;
  logic [BUS_N-1:0] take_v;
  logic [BUS_N-1:0] hide_v;
  logic [31:0]      addr_v      [BUS_N];
  logic [1:0]       size_v      [BUS_N];
  logic [31:0]      mem_data_v  [BUS_N];
  logic [31:0]      cpu_data_v  [BUS_N];
  logic [7:0]       byte_data_v [BUS_N];

  // ==========================================================
  // Both buses are watched passively; nothing here can stall them
  assign valid_v[CD]    = bus.cd_valid; // RQ1
  assign valid_v[SB]    = bus.sb_valid; // RQ1
  assign dbg_v[CD]      = bus.cd_dbg;
  assign dbg_v[SB]      = bus.sb_dbg;
  assign zone_v[CD]     = bus.cd_zone;
  assign zone_v[SB]     = bus.sb_zone;
  assign owner_v[CD]    = bus.cd_owner_zone;
  assign owner_v[SB]    = bus.sb_owner_zone;
  assign prot_v[CD]     = bus.cd_protected;
  assign prot_v[SB]     = bus.sb_protected;
  assign xonly_v[CD]    = bus.cd_exec_only;
  assign xonly_v[SB]    = bus.sb_exec_only;
  assign addr_v[CD]     = bus.cd_addr;
  assign addr_v[SB]     = bus.sb_addr;
  assign size_v[CD]     = bus.cd_size;
  assign size_v[SB]     = bus.sb_size;
  assign mem_data_v[CD] = bus.cd_mem_data;
  assign mem_data_v[SB] = bus.sb_mem_data;

  // ==========================================================
  // Read qualification and CPU data, one copy per bus
  genvar gi;
  generate
    for (gi = 0; gi < BUS_N; gi++) begin : g_bus
      logic mirror_hit;
      logic byte_read;
      logic secure_hit;
      logic foreign;
      assign mirror_hit = addr_v[gi][snoop_crc_pkg::MIRROR_BIT]; // RQ2
      assign byte_read  = (size_v[gi] == snoop_crc_pkg::SIZE_BYTE); // RQ5
      assign secure_hit = prot_v[gi] || xonly_v[gi];
      // Own-zone code may read its secure memory; the debugger never may
      assign foreign    = dbg_v[gi] || (zone_v[gi] != owner_v[gi]);
      assign blocked_v[gi] = secure_hit && foreign; // RQ13
      assign take_v[gi] = valid_v[gi] && mirror_hit && byte_read && !dbg_v[gi]
                          && !blocked_v[gi]; // RQ6 RQ14
      // Execute-only data goes to the fold chain only, never to the core
      assign hide_v[gi]      = blocked_v[gi] || xonly_v[gi]; // RQ15
      assign cpu_data_v[gi]  = hide_v[gi] ? snoop_crc_pkg::ZERO_WORD : mem_data_v[gi]; // RQ16
      assign byte_data_v[gi] = mem_data_v[gi][snoop_crc_pkg::BYTE_W-1:0];
    end
  endgenerate

  // ==========================================================
  // Read data handed back to the core
  assign bus.cd_cpu_data = cpu_data_v[CD];
  assign bus.sb_cpu_data = cpu_data_v[SB];

  // ==========================================================
  // Polynomial selection register; a new choice only affects bytes
  // folded from the next cycle on
  snoop_crc_pkg::poly_sel_t crc_polynomial_select_reg;
  snoop_crc_pkg::poly_sel_t crc_polynomial_select_nxt;

  always_comb begin
    crc_polynomial_select_nxt = crc_polynomial_select_reg;
    if (bus.sw_cfg_we) begin
      crc_polynomial_select_nxt = snoop_crc_pkg::poly_sel_t'(bus.sw_cfg_val); // RQ10
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_polynomial_select_reg <= snoop_crc_pkg::POLY_CRC8;
    end else begin
      crc_polynomial_select_reg <= crc_polynomial_select_nxt;
    end
  end
  assign bus.cfg_readback = crc_polynomial_select_reg;

  // ==========================================================
  // Fold chain: both buses may hit in one cycle, so stage gi starts
  // from what stage gi-1 left; the code-data byte is folded first
  logic [31:0] crc_result_reg;
  logic [31:0] crc_result_nxt;
  logic [31:0] chain_v [BUS_N+1];
  logic [31:0] step_v  [BUS_N];

  assign chain_v[0] = crc_result_reg;
  generate
    for (gi = 0; gi < BUS_N; gi++) begin : g_fold
      crc_byte_step crc_byte_step_inst (
        .crc_i  (chain_v[gi]),
        .data_i (byte_data_v[gi]),
        .sel_i  (crc_polynomial_select_reg),
        .crc_o  (step_v[gi])
      ); // RQ7 RQ8 RQ17
      assign chain_v[gi+1] = take_v[gi] ? step_v[gi] : chain_v[gi]; // RQ3
    end
  endgenerate

  // ==========================================================
  // Result register: clear beats load beats snooped bytes, so a
  // restore can never be half overwritten by a stray fold
  always_comb begin
    crc_result_nxt = chain_v[BUS_N]; // RQ3
    if (bus.sw_clear) begin
      crc_result_nxt = snoop_crc_pkg::CRC_CLEAR; // RQ9 RQ17
    end else if (bus.sw_load) begin
      crc_result_nxt = bus.sw_load_val; // RQ11
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_result_reg <= snoop_crc_pkg::CRC_CLEAR;
    end else begin
      crc_result_reg <= crc_result_nxt;
    end
  end
  assign bus.crc_result = crc_result_reg; // RQ4
endmodule : snoop_crc_unit
`default_nettype wire

// [rtl/snoop_crc_pkg.sv]
`default_nettype none
package snoop_crc_pkg;
  // ==========================================================
  // Polynomial selection
  typedef enum logic [1:0] {
    POLY_CRC8,
    POLY_CRC16_FIRST,
    POLY_CRC16_SECOND,
    POLY_CRC32
  } poly_sel_t;

  // ==========================================================
  // Generator polynomials, MSB-first, no reflection
  localparam logic [31:0] POLY8_VAL   = 32'h0000_0007;
  localparam logic [31:0] POLY16A_VAL = 32'h0000_8005;
  localparam logic [31:0] POLY16B_VAL = 32'h0000_1021;
  localparam logic [31:0] POLY32_VAL  = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_CLEAR   = 32'h0000_0000;

  // ==========================================================
  // Bus transfer sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // ==========================================================
  // Mirrored alias region: address bit that marks a mirrored access
  localparam int          ADDR_W      = 32;
  localparam int          MIRROR_BIT  = 28;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  // ==========================================================
  // Lane and CRC widths
  localparam int          BYTE_W      = 8;
  localparam int          CRC8_W      = 8;
  localparam int          CRC16_W     = 16;
  localparam int          CRC32_W     = 32;
endpackage : snoop_crc_pkg
`default_nettype wire

// [rtl/snoop_bus_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface snoop_bus_if;
  // Code-data bus read beat
  logic        cd_valid;
  logic [31:0] cd_addr;
  logic [1:0]  cd_size;
  logic        cd_dbg;
  logic        cd_zone;
  logic        cd_exec_only;
  logic        cd_owner_zone;
  logic        cd_protected;
  logic [31:0] cd_mem_data;
  logic [31:0] cd_cpu_data;
  // System bus read beat
  logic        sb_valid;
  logic [31:0] sb_addr;
  logic [1:0]  sb_size;
  logic        sb_dbg;
  logic        sb_zone;
  logic        sb_exec_only;
  logic        sb_owner_zone;
  logic        sb_protected;
  logic [31:0] sb_mem_data;
  logic [31:0] sb_cpu_data;
  // Register access from software
  logic        sw_clear;
  logic        sw_load;
  logic [31:0] sw_load_val;
  logic        sw_cfg_we;
  logic [1:0]  sw_cfg_val;
  logic [31:0] crc_result;
  logic [1:0]  cfg_readback;

  modport unit (
    input  cd_valid, cd_addr, cd_size, cd_dbg, cd_zone, cd_exec_only, cd_owner_zone,
    input  cd_protected, cd_mem_data,
    input  sb_valid, sb_addr, sb_size, sb_dbg, sb_zone, sb_exec_only, sb_owner_zone,
    input  sb_protected, sb_mem_data,
    input  sw_clear, sw_load, sw_load_val, sw_cfg_we, sw_cfg_val,
    output cd_cpu_data, sb_cpu_data, crc_result, cfg_readback
  );
  modport core (
    output cd_valid, cd_addr, cd_size, cd_dbg, cd_zone, cd_exec_only, cd_owner_zone,
    output cd_protected, cd_mem_data,
    output sb_valid, sb_addr, sb_size, sb_dbg, sb_zone, sb_exec_only, sb_owner_zone,
    output sb_protected, sb_mem_data,
    output sw_clear, sw_load, sw_load_val, sw_cfg_we, sw_cfg_val,
    input  cd_cpu_data, sb_cpu_data, crc_result, cfg_readback
  );
endinterface : snoop_bus_if
`default_nettype wire

// [rtl/crc_byte_step.sv]
`timescale 1ns/1ps
`default_nettype none
module crc_byte_step (
  input  wire logic [31:0]                 crc_i,
  input  wire logic [7:0]                  data_i,
  input  wire snoop_crc_pkg::poly_sel_t    sel_i,
  output logic      [31:0]                 crc_o
);
  // ==========================================================
  // One byte, MSB first, CRC held in the low bits of the word
  function automatic logic [31:0] step(input logic [31:0] c_in,
                                       input logic [7:0] d,
                                       input logic [31:0] poly,
                                       input int w);
    logic [31:0] c;
    logic        fb;
    c = c_in;
    for (int i = snoop_crc_pkg::BYTE_W - 1; i >= 0; i--) begin
      fb = c[w-1] ^ d[i];
      c  = c << 1;
      if (fb) begin
        c = c ^ poly;
      end
    end
    for (int k = 0; k < snoop_crc_pkg::CRC32_W; k++) begin
      if (k >= w) begin
        c[k] = 1'b0;
      end
    end
    return c;
  endfunction : step

  always_comb begin
    case (sel_i)
      snoop_crc_pkg::POLY_CRC8:         crc_o = step(crc_i, data_i, snoop_crc_pkg::POLY8_VAL,
                                                     snoop_crc_pkg::CRC8_W);
      snoop_crc_pkg::POLY_CRC16_FIRST:  crc_o = step(crc_i, data_i, snoop_crc_pkg::POLY16A_VAL,
                                                     snoop_crc_pkg::CRC16_W);
      snoop_crc_pkg::POLY_CRC16_SECOND: crc_o = step(crc_i, data_i, snoop_crc_pkg::POLY16B_VAL,
                                                     snoop_crc_pkg::CRC16_W);
      default:                          crc_o = step(crc_i, data_i, snoop_crc_pkg::POLY32_VAL,
                                                     snoop_crc_pkg::CRC32_W);
    endcase
  end
endmodule : crc_byte_step
`default_nettype wire

// [rtl/snoop_core_end.sv]
`timescale 1ns/1ps
`default_nettype none
module snoop_core_end (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  snoop_bus_if.core        bus,
  // Software side
  input  wire logic        clear_i,
  input  wire logic        load_i,
  input  wire logic [31:0] load_val_i,
  input  wire logic        cfg_we_i,
  input  wire logic [1:0]  cfg_val_i,
  // Code-data bus beat
  input  wire logic        cd_valid_i,
  input  wire logic [31:0] cd_addr_i,
  input  wire logic [1:0]  cd_size_i,
  input  wire logic        cd_dbg_i,
  input  wire logic        cd_zone_i,
  input  wire logic        cd_exec_only_i,
  input  wire logic        cd_owner_zone_i,
  input  wire logic        cd_protected_i,
  input  wire logic [31:0] cd_mem_data_i,
  // System bus beat
  input  wire logic        sb_valid_i,
  input  wire logic [31:0] sb_addr_i,
  input  wire logic [1:0]  sb_size_i,
  input  wire logic        sb_dbg_i,
  input  wire logic        sb_zone_i,
  input  wire logic        sb_exec_only_i,
  input  wire logic        sb_owner_zone_i,
  input  wire logic        sb_protected_i,
  input  wire logic [31:0] sb_mem_data_i,
  output logic      [31:0] cd_cpu_data_o,
  output logic      [31:0] sb_cpu_data_o,
  output logic      [31:0] result_o,
  output logic      [1:0]  cfg_o
);
  // ==========================================================
  // Software ordering is the caller's job: save, clear, select,
  // read mirrored data, read result, restore
  assign bus.sw_clear      = clear_i; // RQ9 RQ12
  assign bus.sw_load       = load_i; // RQ11
  assign bus.sw_load_val   = load_val_i;
  assign bus.sw_cfg_we     = cfg_we_i; // RQ10
  assign bus.sw_cfg_val    = cfg_val_i;
  assign bus.cd_valid      = cd_valid_i;
  assign bus.cd_addr       = cd_addr_i;
  assign bus.cd_size       = cd_size_i;
  assign bus.cd_dbg        = cd_dbg_i;
  assign bus.cd_zone       = cd_zone_i;
  assign bus.cd_exec_only  = cd_exec_only_i;
  assign bus.cd_owner_zone = cd_owner_zone_i;
  assign bus.cd_protected  = cd_protected_i;
  assign bus.cd_mem_data   = cd_mem_data_i;
  assign bus.sb_valid      = sb_valid_i;
  assign bus.sb_addr       = sb_addr_i;
  assign bus.sb_size       = sb_size_i;
  assign bus.sb_dbg        = sb_dbg_i;
  assign bus.sb_zone       = sb_zone_i;
  assign bus.sb_exec_only  = sb_exec_only_i;
  assign bus.sb_owner_zone = sb_owner_zone_i;
  assign bus.sb_protected  = sb_protected_i;
  assign bus.sb_mem_data   = sb_mem_data_i;

  // ==========================================================
  // Read data returned to the CPU is registered
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cd_cpu_data_o <= snoop_crc_pkg::ZERO_WORD;
      sb_cpu_data_o <= snoop_crc_pkg::ZERO_WORD;
    end else begin
      cd_cpu_data_o <= bus.cd_cpu_data;
      sb_cpu_data_o <= bus.sb_cpu_data;
    end
  end
  assign result_o = bus.crc_result;
  assign cfg_o    = bus.cfg_readback;
endmodule : snoop_core_end
`default_nettype wire

// [tb/snoop_crc_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module snoop_crc_assertions (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        cd_valid,
  input wire logic [31:0] cd_addr,
  input wire logic [1:0]  cd_size,
  input wire logic        cd_dbg,
  input wire logic        cd_protected,
  input wire logic        cd_exec_only,
  input wire logic [31:0] cd_cpu_data,
  input wire logic        cd_zone,
  input wire logic        cd_owner_zone,
  input wire logic [31:0] cd_mem_data,
  input wire logic        sb_valid,
  input wire logic        sw_clear,
  input wire logic        sw_load,
  input wire logic [31:0] sw_load_val,
  input wire logic        sw_cfg_we,
  input wire logic [1:0]  sw_cfg_val,
  input wire logic [31:0] crc_result,
  input wire logic [1:0]  cfg_readback
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Nothing else may move the result in that cycle
  sequence s_quiet;
    !sw_clear && !sw_load && !sb_valid;
  endsequence

  AST_CLEAR: assert property (sw_clear |=> crc_result == 32'h0000_0000)
    else $error("result not zero after clear");
  AST_LOAD: assert property (sw_load && !sw_clear && !sw_cfg_we && cfg_readback == 2'h3
    |=> crc_result == $past(sw_load_val)) else $error("loaded value not taken");
  AST_CFG: assert property (sw_cfg_we |=> cfg_readback == $past(sw_cfg_val))
    else $error("polynomial select not written");
  AST_SIZE: assert property ((cd_valid && cd_size != snoop_crc_pkg::SIZE_BYTE) ##0 s_quiet
    |=> $stable(crc_result)) else $error("wide read changed result");
  AST_DEBUG: assert property ((cd_valid && cd_dbg) ##0 s_quiet |=> $stable(crc_result))
    else $error("debugger read changed result");
  AST_MIRROR: assert property ((cd_valid && !cd_addr[snoop_crc_pkg::MIRROR_BIT]) ##0 s_quiet
    |=> $stable(crc_result)) else $error("plain address changed result");
  AST_PROT: assert property (cd_valid && cd_protected && (cd_dbg || cd_zone != cd_owner_zone)
    |-> cd_cpu_data == 32'h0000_0000) else $error("protected read not zero");
  AST_OWN_ZONE: assert property (cd_valid && cd_protected && !cd_exec_only && !cd_dbg
    && cd_zone == cd_owner_zone |-> cd_cpu_data == cd_mem_data)
    else $error("own-zone secure read lost its data");
  AST_XONLY: assert property (cd_valid && cd_exec_only |-> cd_cpu_data == 32'h0000_0000)
    else $error("execute-only data reached the core");
endmodule : snoop_crc_assertions
`default_nettype wire

// [tb/bus_snoop_crc_unit_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module bus_snoop_crc_unit_tb;
  typedef struct packed {
    logic v; logic [31:0] a; logic [1:0] sz; logic dbg, zn, xo, own, prot; logic [31:0] d;
  } beat_t;
  typedef struct packed {
    logic [1:0] poly; logic [1:0] sz; logic mir, dbg, sys, take; logic [7:0] d;
  } row_t;
  localparam row_t ROWS [8] = '{
    '{2'h0, 2'h0, 1'h1, 1'h0, 1'h0, 1'h1, 8'h31}, '{2'h1, 2'h0, 1'h1, 1'h0, 1'h1, 1'h1, 8'hA5},
    '{2'h2, 2'h0, 1'h1, 1'h0, 1'h0, 1'h1, 8'h5C}, '{2'h3, 2'h0, 1'h1, 1'h0, 1'h1, 1'h1, 8'hFF},
    '{2'h3, 2'h1, 1'h1, 1'h0, 1'h0, 1'h0, 8'h12}, '{2'h3, 2'h2, 1'h1, 1'h0, 1'h1, 1'h0, 8'h34},
    '{2'h3, 2'h0, 1'h1, 1'h1, 1'h0, 1'h0, 8'h56}, '{2'h3, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h78}};
  logic        clk, rst_n, clr, ld, cwe;
  logic [31:0] ldv, res, cdo, sbo;
  logic [1:0]  cval, cfg;
  beat_t       cd, sb, b;
  int          fails, checks_done;

  snoop_bus_if bif ();
  snoop_crc_unit snoop_crc_unit_inst (.core_clk_i(clk), .rst_n_i(rst_n), .bus(bif.unit));
  snoop_core_end snoop_core_end_inst (
    .core_clk_i(clk), .rst_n_i(rst_n), .bus(bif.core), .clear_i(clr), .load_i(ld),
    .load_val_i(ldv), .cfg_we_i(cwe), .cfg_val_i(cval),
    .cd_valid_i(cd.v), .cd_addr_i(cd.a), .cd_size_i(cd.sz), .cd_dbg_i(cd.dbg),
    .cd_zone_i(cd.zn), .cd_exec_only_i(cd.xo), .cd_owner_zone_i(cd.own),
    .cd_protected_i(cd.prot), .cd_mem_data_i(cd.d),
    .sb_valid_i(sb.v), .sb_addr_i(sb.a), .sb_size_i(sb.sz), .sb_dbg_i(sb.dbg),
    .sb_zone_i(sb.zn), .sb_exec_only_i(sb.xo), .sb_owner_zone_i(sb.own),
    .sb_protected_i(sb.prot), .sb_mem_data_i(sb.d),
    .cd_cpu_data_o(cdo), .sb_cpu_data_o(sbo), .result_o(res), .cfg_o(cfg));
  snoop_crc_assertions snoop_crc_assertions_inst (
    .core_clk_i(clk), .rst_n_i(rst_n), .cd_valid(bif.cd_valid), .cd_addr(bif.cd_addr),
    .cd_size(bif.cd_size), .cd_dbg(bif.cd_dbg), .cd_protected(bif.cd_protected),
    .cd_exec_only(bif.cd_exec_only), .cd_cpu_data(bif.cd_cpu_data), .sb_valid(bif.sb_valid),
    .cd_zone(bif.cd_zone), .cd_owner_zone(bif.cd_owner_zone), .cd_mem_data(bif.cd_mem_data),
    .sw_clear(bif.sw_clear), .sw_load(bif.sw_load), .sw_load_val(bif.sw_load_val),
    .sw_cfg_we(bif.sw_cfg_we), .sw_cfg_val(bif.sw_cfg_val), .crc_result(bif.crc_result),
    .cfg_readback(bif.cfg_readback));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Plain bitwise model, kept apart from the design's stepping logic on purpose
  function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d,
                                       input logic [1:0] s);
    logic [31:0] p, m;
    logic        fb;
    int          w;
    w = (s == 2'h0) ? 8 : (s == 2'h3) ? 32 : 16;
    p = (s == 2'h0) ? snoop_crc_pkg::POLY8_VAL : (s == 2'h1) ? snoop_crc_pkg::POLY16A_VAL :
        (s == 2'h2) ? snoop_crc_pkg::POLY16B_VAL : snoop_crc_pkg::POLY32_VAL;
    m = (w == 32) ? 32'hFFFF_FFFF : (32'h0000_0001 << w) - 32'h0000_0001;
    for (int i = 7; i >= 0; i--) begin
      fb = c[w-1] ^ d[i];
      c = (c << 1) & m;
      if (fb) c = c ^ p;
    end
    return c;
  endfunction : step
  function automatic beat_t mk(input logic [1:0] sz, input logic mir, dbg, xo, prot, zn, own,
                               input logic [7:0] d);
    return '{1'h1, {3'h0, mir, 28'h000_1000}, sz, dbg, zn, xo, own, prot, {24'hA5_5A3C, d}};
  endfunction : mk
  task automatic tick;
    @(posedge clk);
    cd.v <= 1'h0; sb.v <= 1'h0; clr <= 1'h0; ld <= 1'h0; cwe <= 1'h0;
    #1;
  endtask : tick

  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial begin
    fails = 0; checks_done = 0; rst_n = 1'h0; clr = 1'h0; ld = 1'h0; cwe = 1'h0;
    ldv = 32'h0000_0000; cval = 2'h0; cd = '0; sb = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    check(res, 32'h0000_0000);
    check({30'h0, cfg}, 32'h0000_0000);
    foreach (ROWS[i]) begin
      @(posedge clk); cwe <= 1'h1; cval <= ROWS[i].poly; clr <= 1'h1;
      tick();
      b = mk(ROWS[i].sz, ROWS[i].mir, ROWS[i].dbg, 1'h0, 1'h0, 1'h0, 1'h0, ROWS[i].d);
      @(posedge clk);
      if (ROWS[i].sys) sb <= b;
      else cd <= b;
      tick();
      check(res, ROWS[i].take ? step(0, ROWS[i].d, ROWS[i].poly) : 0);
      check(ROWS[i].sys ? sbo : cdo, b.d);
    end
    // Restore a saved value, then both buses in one cycle: code-data folds first
    @(posedge clk); ld <= 1'h1; ldv <= 32'h1234_5678;
    tick();
    check(res, 32'h1234_5678);
    @(posedge clk); cd <= mk(2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h9A);
    sb <= mk(2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h3C);
    tick();
    check(res, step(step(32'h1234_5678, 8'h9A, 2'h3), 8'h3C, 2'h3));
    @(posedge clk); clr <= 1'h1; ld <= 1'h1; cd <= mk(2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h11);
    tick();
    check(res, 32'h0000_0000);
    @(posedge clk); cd <= mk(2'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 8'h44);
    tick();
    check(res, 32'h0000_0000);
    check(cdo, 32'h0000_0000);
    @(posedge clk); cd <= mk(2'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 8'h44);
    tick();
    check(res, step(0, 8'h44, 2'h3));
    check(cdo, 32'h0000_0000);
    // Own-zone secure read feeds the CRC and the core; a foreign one feeds neither
    @(posedge clk); cd <= mk(2'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 8'h21);
    sb <= mk(2'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 8'h66);
    tick();
    check(res, step(step(0, 8'h44, 2'h3), 8'h21, 2'h3));
    check(cdo, {24'hA5_5A3C, 8'h21});
    check(sbo, 32'h0000_0000);
    @(posedge clk); rst_n <= 1'h0;
    @(posedge clk); rst_n <= 1'h1;
    #1;
    check(res, 32'h0000_0000);
    check({30'h0, cfg}, 32'h0000_0000);
    summarize();
  end
endmodule : bus_snoop_crc_unit_tb
`default_nettype wire
